// [sim/tb_instr_subset_exec_unit.sv]
// Bench for the instruction subset execution unit over AXI4-Lite
// Assumes the unit's register map, a 20 MHz clock and synchronous reset
`timescale 1ns/1ps
`include "exec_defs.svh"

module tb_instr_subset_exec_unit
	import exec_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        s_axi_awvalid = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000;
	logic        s_axi_wvalid = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0;
	logic [11:0] s_axi_araddr = 12'h000;
	logic        s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] s_axi_rdata, rd;
	logic [7:0]  port_a_direction, port_b_direction, port_c_direction;
	logic        sleeping;
	int          err_count = 0;
	int          checked = 0;

	// Clock at 50 ns period
	always #25 clk = ~clk;

	instr_subset_exec_unit #(.PRE_DIV(64)) instr_subset_exec_unit_inst (
		.clk(clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.port_a_direction(port_a_direction), .port_b_direction(port_b_direction),
		.port_c_direction(port_c_direction), .sleeping(sleeping));

	// ------------------------------------------------
	// Reporting and bus tasks
	// ------------------------------------------------
	task automatic print_verdict();
		begin
			if (err_count == 0 && checked > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask

	task automatic hang();
		begin
			err_count++;
			print_verdict();
		end
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		begin
			checked++;
			if (seen !== exp)
			begin
				err_count++;
				$display("MISMATCH %s expected %h seen %h", name, exp, seen);
			end
		end
	endtask

	// Address and data offered together, each released when taken
	task automatic bus_write(input logic [11:0] a, input logic [31:0] d);
		int n;
		begin
			@(posedge clk);
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			for (n = 0; n < 50; n++)
			begin
				@(posedge clk);
				if (s_axi_awvalid && s_axi_awready === 1'b1)
					s_axi_awvalid <= 1'b0;
				if (s_axi_wvalid && s_axi_wready === 1'b1)
					s_axi_wvalid <= 1'b0;
				if (s_axi_bvalid === 1'b1)
					break;
			end
			if (n == 50)
				hang();
			rsp = s_axi_bresp;
			s_axi_bready <= 1'b0;
		end
	endtask

	task automatic bus_read(input logic [11:0] a);
		int n;
		begin
			@(posedge clk);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			for (n = 0; n < 50; n++)
			begin
				@(posedge clk);
				if (s_axi_arvalid && s_axi_arready === 1'b1)
					s_axi_arvalid <= 1'b0;
				if (s_axi_rvalid === 1'b1)
					break;
			end
			if (n == 50)
				hang();
			rd = s_axi_rdata;
			rsp = s_axi_rresp;
			s_axi_rready <= 1'b0;
		end
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input string name);
		begin
			bus_read(a);
			check(name, rd & m, e);
		end
	endtask

	// Start an instruction, then poll busy until it clears
	task automatic cmd(input logic [3:0] op, input logic d, input logic [7:0] k);
		int n;
		begin
			bus_write(`REG_CMD, {16'h0, k, 3'b000, d, op});
			for (n = 0; n < 20; n++)
			begin
				bus_read(`REG_STATUS);
				if (rd[6] === 1'b0)
					break;
			end
			if (n == 20)
				hang();
		end
	endtask

	// ------------------------------------------------
	// Scenarios
	// ------------------------------------------------
	task automatic t_reset();
		begin
			rd_chk(`REG_STATUS, 32'h7f, 32'h18, "rst_status");
			rd_chk(`REG_DIR, 32'hffffff, 32'hffffff, "rst_dir");
			rd_chk(`REG_PC, 32'h7fff, 32'h0, "rst_pc");
		end
	endtask

	// Subtract against plain difference and compare-based carry
	task automatic sub_case(input logic [3:0] op, input logic [7:0] m, w, input logic cf, d);
		logic [7:0] res;
		logic       b;
		logic       c;
		logic       dc;
		begin
			b = (op == `OPC_SUBFB) ? !cf : 1'b0;
			res = m - w - {7'h0, b};
			c = ({1'b0, w} + {8'h0, b}) <= {1'b0, m};
			dc = ({1'b0, w[3:0]} + {4'h0, b}) <= {1'b0, m[3:0]};
			bus_write(`REG_ACC, {24'h0, w});
			bus_write(`REG_STATUS, {31'h0, cf});
			bus_write(12'h240, {24'h0, m});
			cmd(op, d, (op == `OPC_SUBL) ? m : 8'h10);
			rd_chk(`REG_ACC, 32'hff, {24'h0, d ? w : res}, "sub_acc");
			rd_chk(12'h240, 32'hff, {24'h0, d ? res : m}, "sub_file");
			rd_chk(`REG_STATUS, 32'h7, {29'h0, res == 8'h0, dc, c}, "sub_flags");
		end
	endtask

	task automatic t_sub();
		begin
			sub_case(`OPC_SUBL, 8'h03, 8'h05, 1'b0, 1'b0);
			sub_case(`OPC_SUBL, 8'h03, 8'h03, 1'b0, 1'b0);
			sub_case(`OPC_SUBL, 8'h10, 8'h0f, 1'b0, 1'b0);
			sub_case(`OPC_SUBL, 8'hff, 8'h00, 1'b0, 1'b0);
			sub_case(`OPC_SUBF, 8'h80, 8'h81, 1'b0, 1'b0);
			sub_case(`OPC_SUBF, 8'h42, 8'h42, 1'b0, 1'b1);
			sub_case(`OPC_SUBFB, 8'h10, 8'h0f, 1'b0, 1'b1);
			sub_case(`OPC_SUBFB, 8'h20, 8'h30, 1'b1, 1'b0);
		end
	endtask

	task automatic t_swap();
		begin
			bus_write(12'h214, 32'h3c);
			bus_write(`REG_ACC, 32'h11);
			bus_write(`REG_STATUS, 32'h5);
			cmd(`OPC_SWAP, 1'b0, 8'h05);
			rd_chk(`REG_ACC, 32'hff, 32'hc3, "swap_acc");
			rd_chk(12'h214, 32'hff, 32'h3c, "swap_keep");
			cmd(`OPC_SWAP, 1'b1, 8'h05);
			rd_chk(12'h214, 32'hff, 32'hc3, "swap_file");
			rd_chk(`REG_STATUS, 32'h7, 32'h5, "swap_flags");
		end
	endtask

	task automatic t_dir();
		logic [7:0] k;
		begin
			bus_write(`REG_STATUS, 32'h2);
			for (k = 8'h05; k <= 8'h07; k++)
			begin
				bus_write(`REG_ACC, {24'h0, 8'h50 + k});
				cmd(`OPC_DIR, 1'b0, k);
			end
			check("dir_a", {24'h0, port_a_direction}, 32'h55);
			check("dir_b", {24'h0, port_b_direction}, 32'h56);
			check("dir_c", {24'h0, port_c_direction}, 32'h57);
			bus_write(`REG_ACC, 32'h99);
			cmd(`OPC_DIR, 1'b0, 8'h04);
			bus_write(`REG_DIR, 32'h0);
			rd_chk(`REG_DIR, 32'hffffff, 32'h575655, "dir_reg");
			rd_chk(`REG_STATUS, 32'h7, 32'h2, "dir_flags");
		end
	endtask

	task automatic t_xor();
		begin
			bus_write(`REG_ACC, 32'ha5);
			bus_write(`REG_STATUS, 32'h3);
			cmd(`OPC_XORL, 1'b0, 8'ha5);
			rd_chk(`REG_ACC, 32'hff, 32'h0, "xor_acc");
			rd_chk(`REG_STATUS, 32'h7, 32'h7, "xor_z");
			cmd(`OPC_XORL, 1'b0, 8'h3c);
			rd_chk(`REG_ACC, 32'hff, 32'h3c, "xor_acc2");
			rd_chk(`REG_STATUS, 32'h7, 32'h3, "xor_nz");
		end
	endtask

	task automatic t_ret();
		begin
			bus_write(`REG_STACK, 32'h1234);
			bus_write(`REG_STATUS, 32'h3);
			cmd(`OPC_RET, 1'b0, 8'h00);
			rd_chk(`REG_PC, 32'h7fff, 32'h1234, "ret_pc");
			rd_chk(`REG_STACK, 32'hff000000, 32'h0, "ret_sp");
			rd_chk(`REG_STATUS, 32'h1f, 32'h1b, "ret_flags");
		end
	endtask

	task automatic t_sleep();
		int n;
		begin
			bus_read(`REG_WDT);
			check("wdt_running", {31'h0, rd[15:0] != 16'h0}, 32'h1);
			// Wait for a prescaler high enough that a missed clear shows
			for (n = 0; n < 40; n++)
			begin
				if (rd[31:16] >= 16'h20 && rd[31:16] < 16'h30)
					break;
				bus_read(`REG_WDT);
			end
			if (n == 40)
				hang();
			bus_write(`REG_STATUS, 32'h5);
			cmd(`OPC_SLEEP, 1'b0, 8'h00);
			bus_read(`REG_WDT);
			check("wdt_cnt", {16'h0, rd[15:0]}, 32'h0);
			check("wdt_pre", {31'h0, rd[31:16] < 16'h20}, 32'h1);
			check("sleeping", {31'h0, sleeping}, 32'h1);
			rd_chk(`REG_STATUS, 32'h1f, 32'h15, "sleep_flags");
			cmd(4'h0, 1'b0, 8'h00);
			check("awake", {31'h0, sleeping}, 32'h0);
		end
	endtask

	task automatic t_bad();
		begin
			bus_write(12'h100, 32'h77);
			check("bad_bresp", {30'h0, rsp}, {30'h0, `RESP_ERR});
			bus_read(12'h100);
			check("bad_rresp", {30'h0, rsp}, {30'h0, `RESP_ERR});
		end
	endtask

	// Main sequence
	initial
	begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_sub();
		t_swap();
		t_dir();
		t_xor();
		t_ret();
		t_sleep();
		t_bad();
		print_verdict();
	end
endmodule

// [src/exec_defs.svh]
// Offsets, field positions, opcodes and reset values of the execution unit
// Included by the unit and its testbench; no logic here
`ifndef EXEC_DEFS_SVH
`define EXEC_DEFS_SVH

// ---------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------
`define REG_CMD    12'h000
`define REG_ACC    12'h004
`define REG_STATUS 12'h008
`define REG_PC     12'h00c
`define REG_STACK  12'h010
`define REG_DIR    12'h014
`define REG_WDT    12'h018
`define FILE_BASE  3'b001
`define FILE_HI    11
`define FILE_LO    9

// ---------------------------------------------------------------
// Command fields and opcodes
// ---------------------------------------------------------------
`define CMD_OP_HI  3
`define CMD_D_BIT  4
`define CMD_K_HI   15
`define CMD_K_LO   8
`define OPC_RET    4'h1
`define OPC_SLEEP  4'h2
`define OPC_SUBL   4'h3
`define OPC_SUBF   4'h4
`define OPC_SUBFB  4'h5
`define OPC_SWAP   4'h6
`define OPC_DIR    4'h7
`define OPC_XORL   4'h8
`define DIR_SEL_A  8'h05
`define DIR_SEL_B  8'h06
`define DIR_SEL_C  8'h07

// ---------------------------------------------------------------
// Status bits, reset values, watchdog, bus answers
// ---------------------------------------------------------------
`define ST_C       0
`define ST_DC      1
`define ST_Z       2
`define DIR_RESET  8'hff
`define WDT_PRE    16
`define RESP_OKAY  2'b00
`define RESP_ERR   2'b10

`endif

// [src/exec_pkg.sv]
// Types shared by the execution unit and its subtractor
// Needs exec_defs.svh nowhere; plain type definitions
package exec_pkg;

	// Execution phases
	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_RET2} exec_state_t;

	// Status flags, bit 0 is carry
	typedef struct packed {
		logic timeout_flag;
		logic power_down_flag;
		logic z;
		logic digit_carry_flag;
		logic c;
	} flags_t;

	// Subtractor answer
	typedef struct packed {
		logic [7:0] res;
		logic       c;
		logic       dc;
	} alu_out_t;

endpackage

// [src/instr_subset_exec_unit.sv]
// Execution unit for a subset of an 8-bit core's instructions, AXI4-Lite slave
// Assumes one clock, synchronous active-high reset, a well-behaved bus master
`timescale 1ns/1ps
`include "exec_defs.svh"

module instr_subset_exec_unit
	import exec_pkg::*;
#(
	parameter int PC_W    = 15,
	parameter int DEPTH   = 16,
	parameter int NFILE   = 128,
	parameter int WDT_W   = 8,
	parameter int PRE_DIV = `WDT_PRE
)
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [11:0] s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic [7:0]       port_a_direction,
	output logic [7:0]       port_b_direction,
	output logic [7:0]       port_c_direction,
	output logic             sleeping
);
	localparam int SP_W  = $clog2(DEPTH);
	localparam int FA_W  = $clog2(NFILE);
	localparam int PRE_W = $clog2(PRE_DIV);

	typedef struct packed {
		exec_state_t                state;
		logic                       awready;
		logic                       wready;
		logic                       arready;
		logic                       aw_got;
		logic                       w_got;
		logic [11:0]                waddr;
		logic [31:0]                wdata;
		logic [3:0]                 wstrb;
		logic                       bvalid;
		logic [1:0]                 bresp;
		logic                       rvalid;
		logic [31:0]                rdata;
		logic [1:0]                 rresp;
		logic [3:0]                 op;
		logic                       d;
		logic [7:0]                 k;
		logic [7:0]                 acc;
		flags_t                     flags;
		logic                       sleeping;
		logic [PC_W-1:0]            pc;
		logic [DEPTH-1:0][PC_W-1:0] stack;
		logic [SP_W-1:0]            sp;
		logic [NFILE-1:0][7:0]      file;
		logic [7:0]                 dir_a;
		logic [7:0]                 dir_b;
		logic [7:0]                 dir_c;
		logic [WDT_W-1:0]           watchdog_counter;
		logic [PRE_W-1:0]           pre;
	} state_t;

	state_t          st;
	state_t          next_st;
	alu_out_t        alu;
	logic [7:0]      fsel;
	logic [7:0]      swapped;
	logic [PC_W-1:0] stack_top;
	logic [7:0]      minuend;
	logic            carry_in;

	// ---------------------------------------------------------------
	// Helper functions
	// ---------------------------------------------------------------
	function automatic logic is_zero(input logic [7:0] v);
		return v == 8'h00;
	endfunction

	function automatic logic is_file(input logic [11:0] a);
		return a[`FILE_HI:`FILE_LO] == `FILE_BASE;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		end
		return r;
	endfunction

	// ---------------------------------------------------------------
	// Operand selection and subtractor
	// ---------------------------------------------------------------
	assign fsel      = st.file[st.k[FA_W-1:0]];
	assign swapped   = {fsel[3:0], fsel[7:4]};
	assign stack_top = st.stack[st.sp - SP_W'(1)];
	assign minuend   = (st.op == `OPC_SUBL) ? st.k : fsel;
	assign carry_in  = (st.op == `OPC_SUBFB) ? st.flags.c : 1'b1;

	sub_borrow_alu sub_borrow_alu_inst (
		.minuend    (minuend),
		.subtrahend (st.acc),
		.carry_in   (carry_in),
		.result     (alu)
	);

	// ---------------------------------------------------------------
	// Next-state logic
	// ---------------------------------------------------------------
	always_comb
	begin
		next_st = st;
		// Watchdog prescaler and counter
		if (st.pre == PRE_W'(PRE_DIV - 1))
		begin
			next_st.pre = '0;
			next_st.watchdog_counter = st.watchdog_counter + WDT_W'(1);
		end
		else
			next_st.pre = st.pre + PRE_W'(1);

		// Instruction execution
		unique case (st.state)
			ST_IDLE: ;
			ST_RET2: next_st.state = ST_IDLE;
			ST_EXEC:
			begin
				next_st.state = ST_IDLE;
				next_st.pc = st.pc + PC_W'(1);
				case (st.op)
					`OPC_RET:
					begin
						next_st.pc = stack_top;
						next_st.sp = st.sp - SP_W'(1);
						next_st.state = ST_RET2;
					end
					`OPC_SLEEP:
					begin
						next_st.flags.power_down_flag = 1'b0;
						next_st.flags.timeout_flag = 1'b1;
						next_st.watchdog_counter = '0;
						next_st.pre = '0;
						next_st.sleeping = 1'b1;
					end
					`OPC_SUBL:
					begin
						next_st.acc = alu.res;
						next_st.flags.c = alu.c;
						next_st.flags.digit_carry_flag = alu.dc;
						next_st.flags.z = is_zero(alu.res);
					end
					`OPC_SUBF, `OPC_SUBFB:
					begin
						if (st.d)
							next_st.file[st.k[FA_W-1:0]] = alu.res;
						else
							next_st.acc = alu.res;
						next_st.flags.c = alu.c;
						next_st.flags.digit_carry_flag = alu.dc;
						next_st.flags.z = is_zero(alu.res);
					end
					`OPC_SWAP:
					begin
						if (st.d)
							next_st.file[st.k[FA_W-1:0]] = swapped;
						else
							next_st.acc = swapped;
					end
					`OPC_DIR:
					begin
						if (st.k == `DIR_SEL_A)
							next_st.dir_a = st.acc;
						if (st.k == `DIR_SEL_B)
							next_st.dir_b = st.acc;
						if (st.k == `DIR_SEL_C)
							next_st.dir_c = st.acc;
					end
					`OPC_XORL:
					begin
						next_st.acc = st.acc ^ st.k;
						next_st.flags.z = is_zero(st.acc ^ st.k);
					end
					default: ;
				endcase
			end
		endcase

		// Write channel capture and response
		if (s_axi_bready && st.bvalid)
			next_st.bvalid = 1'b0;
		if (s_axi_awvalid && st.awready)
		begin
			next_st.aw_got = 1'b1;
			next_st.waddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st.wready)
		begin
			next_st.w_got = 1'b1;
			next_st.wdata = s_axi_wdata;
			next_st.wstrb = s_axi_wstrb;
		end
		if (st.aw_got && st.w_got && !st.bvalid && st.state == ST_IDLE)
		begin
			next_st.aw_got = 1'b0;
			next_st.w_got = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = `RESP_OKAY;
			if (is_file(st.waddr))
			begin
				if (st.wstrb[0])
					next_st.file[st.waddr[FA_W+1:2]] = st.wdata[7:0];
			end
			else
			begin
				case (st.waddr)
					`REG_CMD:
					begin
						next_st.op = st.wdata[`CMD_OP_HI:0];
						next_st.d = st.wdata[`CMD_D_BIT];
						next_st.k = st.wdata[`CMD_K_HI:`CMD_K_LO];
						next_st.state = ST_EXEC;
						next_st.sleeping = 1'b0;
					end
					`REG_ACC:
						if (st.wstrb[0])
							next_st.acc = st.wdata[7:0];
					`REG_STATUS:
						if (st.wstrb[0])
						begin
							next_st.flags.c = st.wdata[`ST_C];
							next_st.flags.digit_carry_flag = st.wdata[`ST_DC];
							next_st.flags.z = st.wdata[`ST_Z];
						end
					`REG_PC:
						next_st.pc = PC_W'(merge(32'(st.pc), st.wdata, st.wstrb));
					`REG_STACK:
					begin
						next_st.stack[st.sp] = st.wdata[PC_W-1:0];
						next_st.sp = st.sp + SP_W'(1);
					end
					`REG_DIR, `REG_WDT: ;
					default: next_st.bresp = `RESP_ERR;
				endcase
			end
		end

		// Read channel
		if (s_axi_rready && st.rvalid)
			next_st.rvalid = 1'b0;
		if (s_axi_arvalid && st.arready)
		begin
			next_st.rvalid = 1'b1;
			next_st.rresp = `RESP_OKAY;
			next_st.rdata = '0;
			if (is_file(s_axi_araddr))
				next_st.rdata[7:0] = st.file[s_axi_araddr[FA_W+1:2]];
			else
			begin
				case (s_axi_araddr)
					`REG_CMD:    next_st.rdata = {16'h0000, st.k, 3'b000, st.d, st.op};
					`REG_ACC:    next_st.rdata[7:0] = st.acc;
					`REG_STATUS: next_st.rdata[7:0] = {1'b0, st.state != ST_IDLE, st.sleeping, st.flags};
					`REG_PC:     next_st.rdata[PC_W-1:0] = st.pc;
					`REG_STACK:  next_st.rdata = {8'(st.sp), 8'h00, 16'(stack_top)};
					`REG_DIR:    next_st.rdata = {8'h00, st.dir_c, st.dir_b, st.dir_a};
					`REG_WDT:    next_st.rdata = {16'(st.pre), 16'(st.watchdog_counter)};
					default:     next_st.rresp = `RESP_ERR;
				endcase
			end
		end

		// Ready flags for the next cycle
		next_st.awready = !next_st.aw_got;
		next_st.wready = !next_st.w_got;
		next_st.arready = !next_st.rvalid;
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st <= '0;
			st.state <= ST_IDLE;
			st.flags.power_down_flag <= 1'b1;
			st.flags.timeout_flag <= 1'b1;
			st.dir_a <= `DIR_RESET;
			st.dir_b <= `DIR_RESET;
			st.dir_c <= `DIR_RESET;
		end
		else
			st <= next_st;
	end

	// Outputs straight from state
	assign s_axi_awready    = st.awready;
	assign s_axi_wready     = st.wready;
	assign s_axi_bvalid     = st.bvalid;
	assign s_axi_bresp      = st.bresp;
	assign s_axi_arready    = st.arready;
	assign s_axi_rvalid     = st.rvalid;
	assign s_axi_rdata      = st.rdata;
	assign s_axi_rresp      = st.rresp;
	assign port_a_direction = st.dir_a;
	assign port_b_direction = st.dir_b;
	assign port_c_direction = st.dir_c;
	assign sleeping         = st.sleeping;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	logic ex;
	assign ex = st.state == ST_EXEC;

	property p_ret;
		ex && st.op == `OPC_RET |=> st.pc == $past(stack_top) && st.state == ST_RET2
			##1 st.state == ST_IDLE && $stable(st.flags);
	endproperty
	a_ret: assert property (p_ret) else $error("return did not load stack top in two cycles");

	property p_sleep;
		ex && st.op == `OPC_SLEEP |=> !st.flags.power_down_flag && st.flags.timeout_flag
			&& st.watchdog_counter == '0 && st.pre == '0 && $stable(st.flags.c);
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep flags or watchdog wrong");

	property p_subl;
		ex && st.op == `OPC_SUBL |=> st.acc == 8'($past(st.k) - $past(st.acc))
			&& st.flags.c == ($past(st.acc) <= $past(st.k));
	endproperty
	a_subl: assert property (p_subl) else $error("literal subtract result or carry wrong");

	property p_subl_dc;
		ex && st.op == `OPC_SUBL |=> st.flags.digit_carry_flag == ($past(st.acc[3:0]) <= $past(st.k[3:0]));
	endproperty
	a_subl_dc: assert property (p_subl_dc) else $error("literal subtract digit carry wrong");

	property p_subf;
		ex && st.op == `OPC_SUBF && !st.d |=> st.acc == 8'($past(fsel) - $past(st.acc))
			&& st.flags.c == ($past(st.acc) <= $past(fsel));
	endproperty
	a_subf: assert property (p_subf) else $error("file subtract to accumulator wrong");

	property p_subfb;
		ex && st.op == `OPC_SUBFB && !st.d |=>
			st.acc == 8'($past(fsel) - $past(st.acc) - 8'(!$past(st.flags.c)));
	endproperty
	a_subfb: assert property (p_subfb) else $error("borrow subtract wrong");

	property p_swap;
		ex && st.op == `OPC_SWAP && st.d |=> $past(swapped) == st.file[$past(st.k[FA_W-1:0])]
			&& $stable(st.flags) && $stable(st.acc);
	endproperty
	a_swap: assert property (p_swap) else $error("swap to file wrong");

	property p_dir;
		ex && st.op == `OPC_DIR && st.k == `DIR_SEL_B |=> port_b_direction == $past(st.acc)
			&& $stable(port_a_direction) && $stable(st.flags);
	endproperty
	a_dir: assert property (p_dir) else $error("direction load to port B wrong");

	property p_xor;
		ex && st.op == `OPC_XORL |=> st.acc == ($past(st.acc) ^ $past(st.k))
			&& st.flags.z == (($past(st.acc) ^ $past(st.k)) == 8'h00) && $stable(st.flags.c);
	endproperty
	a_xor: assert property (p_xor) else $error("xor literal wrong");

	c_ret: cover property (ex && st.op == `OPC_RET ##2 st.state == ST_IDLE);
	c_sleep: cover property (ex && st.op == `OPC_SLEEP ##1 sleeping);
	c_borrow: cover property (ex && st.op == `OPC_SUBFB && !st.flags.c);

endmodule

// [src/sub_borrow_alu.sv]
// Eight-bit subtractor with carry-as-not-borrow and nibble carry
// Purely combinational; caller picks operands and carry in
`timescale 1ns/1ps

module sub_borrow_alu
	import exec_pkg::*;
(
	input  wire logic [7:0] minuend,
	input  wire logic [7:0] subtrahend,
	input  wire logic       carry_in,
	output alu_out_t        result
);
	logic [8:0] sum;
	logic [4:0] low;

	// ---------------------------------------------------------------
	// Two's complement subtract: a + ~b + carry
	// ---------------------------------------------------------------
	assign sum = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'(carry_in);
	assign low = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'(carry_in);
	assign result = '{res: sum[7:0], c: sum[8], dc: low[4]};

endmodule
